/* core/psl_config_load.v */
// Passive serial configuration loader of the target device.
// Assumes the configuration pins are asynchronous to clk; open-drain lines are resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "psl_regs.vh"

module psl_config_load #(
	parameter [31:0] POR_LONG_CYCLES  = `PSL_POR_LONG_MS * 1000 * 1000 / 10,
	parameter [31:0] POR_SHORT_CYCLES = `PSL_POR_SHORT_MS * 1000 * 1000 / 10,
	parameter [31:0] FRAME_BITS       = 32'd64
) (
	// Clock and reset.
	input  wire                   clk,
	input  wire                   rst_n,
	// Configuration pins.
	input  wire                   configRequestN,
	input  wire                   powerOnDelaySelect,
	input  wire                   weakPullupSelectN,
	input  wire                   statusIn,
	output wire                   statusOut,
	output wire                   statusOe,
	input  wire                   loadDoneIn,
	output wire                   loadDoneOut,
	output wire                   loadDoneOe,
	input  wire                   serialLoadClock,
	input  wire                   serialLoadInput,
	input  wire                   userStartupClock,
	output wire                   initDoneOut,
	output wire                   initDoneOe,
	// Options and error input.
	input  wire                   useUserStartupClock,
	input  wire                   autoRestart,
	input  wire                   dataError,
	// User I/O control.
	output reg                    userIoEnable,
	output reg                    weakPullupOn,
	// Bitstream sink.
	output wire [`PSL_WORD_W-1:0] frameData,
	output wire                   frameValid,
	input  wire                   frameReady,
	output reg                    loadOverrun,
	output reg  [2:0]             stage
);

	// ==================================================================
	// Timing counts
	// ==================================================================
	localparam [31:0] ERR_CYCLES  = `PSL_ERR_TIMEOUT_US * `PSL_CLK_MHZ;
	localparam [31:0] OSC_DIV     = `PSL_CLK_MHZ / `PSL_OSC_MHZ;
	localparam [31:0] CD2CU_CYCLES = `PSL_CD2CU_DCLKS * `PSL_SERIAL_LOAD_CLOCK_MAX_PERIOD_NS / 10;

	// ==================================================================
	// Input synchronisers
	// ==================================================================
	reg [1:0] reqSync;
	reg [1:0] statSync;
	reg [1:0] doneSync;
	reg [2:0] dclkSync;
	reg [1:0] dataSync;
	reg [2:0] uclkSync;
	reg [1:0] porSync;
	reg [1:0] pullSync;

	always @(posedge clk) begin
		if (!rst_n) begin
			porSync  <= 2'h0;
			pullSync <= 2'h0;
		end else begin
			porSync  <= {porSync[0], powerOnDelaySelect};
			pullSync <= {pullSync[0], weakPullupSelectN};
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			reqSync  <= 2'h0;
			statSync <= 2'h0;
			doneSync <= 2'h0;
			dclkSync <= 3'h0;
			dataSync <= 2'h0;
			uclkSync <= 3'h0;
		end else begin
			reqSync  <= {reqSync[0], configRequestN}; // RQ25
			statSync <= {statSync[0], statusIn}; // RQ25
			doneSync <= {doneSync[0], loadDoneIn};
			dclkSync <= {dclkSync[1:0], serialLoadClock};
			dataSync <= {dataSync[0], serialLoadInput};
			uclkSync <= {uclkSync[1:0], userStartupClock};
		end
	end

	wire reqHigh  = reqSync[1];
	wire statHigh = statSync[1];
	wire doneHigh = doneSync[1];
	wire dclkRise = dclkSync[1] & ~dclkSync[2];
	wire uclkRise = uclkSync[1] & ~uclkSync[2];

	// ==================================================================
	// Internal oscillator enable
	// ==================================================================
	reg [31:0] oscCnt;
	wire       oscTick = (oscCnt == OSC_DIV - 32'd1);

	always @(posedge clk) begin
		if (!rst_n || oscTick)
			oscCnt <= 32'd0;
		else
			oscCnt <= oscCnt + 32'd1;
	end

	// ==================================================================
	// Stage machine
	// ==================================================================
	reg [31:0] timer;
	reg [31:0] bitCnt;
	reg        reqPrev;
	reg        optInitDone;
	reg        holdStatus;
	reg        holdDone;
	reg [`PSL_WORD_W-1:0] shiftReg;
	reg [2:0]  shiftCnt;
	reg        wordValid;
	wire       wordReady;

	wire reqRise = reqHigh & ~reqPrev;
	wire inConf  = (stage == `PSL_ST_CONF);

	always @(posedge clk) begin
		if (!rst_n) begin
			stage        <= `PSL_ST_POR;
			timer        <= 32'd0;
			bitCnt       <= 32'd0;
			reqPrev      <= 1'b0;
			optInitDone  <= 1'b0;
			holdStatus   <= 1'b1;
			holdDone     <= 1'b1;
			userIoEnable <= 1'b0;
			weakPullupOn <= 1'b0;
			shiftReg     <= {`PSL_WORD_W{1'b0}};
			shiftCnt     <= 3'h0;
			wordValid    <= 1'b0;
			loadOverrun  <= 1'b0;
		end else begin
			reqPrev <= reqHigh;
			if (wordValid && wordReady)
				wordValid <= 1'b0;
			case (stage)
			`PSL_ST_POR: begin
				holdStatus   <= 1'b1; // RQ2
				userIoEnable <= 1'b0; // RQ2
				timer        <= timer + 32'd1;
				if (timer >= (porSync[1] ? POR_SHORT_CYCLES
				                                 : POR_LONG_CYCLES)) begin // RQ1
					holdStatus   <= 1'b0; // RQ6
					weakPullupOn <= ~pullSync[1]; // RQ7
					stage        <= `PSL_ST_RESET;
				end
			end
			`PSL_ST_RESET: begin
				holdDone     <= 1'b1;
				userIoEnable <= 1'b0;
				weakPullupOn <= ~pullSync[1]; // RQ7
				bitCnt       <= 32'd0;
				shiftCnt     <= 3'h0;
				loadOverrun  <= 1'b0;
				optInitDone  <= 1'b0;
				if (!reqHigh)
					holdStatus <= 1'b1;
				else
					holdStatus <= 1'b0; // RQ10
				if (reqHigh && statHigh && !holdStatus) // RQ9
					stage <= `PSL_ST_CONF; // RQ8
			end
			`PSL_ST_CONF: begin
				weakPullupOn <= ~pullSync[1]; // RQ7
				if (dclkRise) begin // RQ12
					shiftReg <= {shiftReg[`PSL_WORD_W-2:0], dataSync[1]};
					shiftCnt <= shiftCnt + 3'h1;
					bitCnt   <= bitCnt + 32'd1;
					if (bitCnt == `PSL_OPT_INITDONE)
						optInitDone <= dataSync[1]; // RQ18
					if (shiftCnt == 3'h7) begin
						if (wordValid)
							loadOverrun <= 1'b1;
						wordValid <= 1'b1;
					end
					if (bitCnt == FRAME_BITS - 32'd1) begin
						holdDone <= 1'b0; // RQ13
						stage    <= `PSL_ST_WAIT;
					end
				end
				if (dataError || loadOverrun) begin // RQ21
					holdStatus <= 1'b1;
					timer      <= 32'd0;
					stage      <= `PSL_ST_ERR;
				end
			end
			`PSL_ST_WAIT: begin
				timer <= 32'd0;
				if (doneHigh) // RQ24
					stage <= `PSL_ST_INIT; // RQ13
			end
			`PSL_ST_INIT: begin
				if (useUserStartupClock) begin
					if (timer < CD2CU_CYCLES) // RQ17
						timer <= timer + 32'd1;
					else if (uclkRise) // RQ15 RQ16
						bitCnt <= bitCnt + 32'd1; // RQ24
				end else if (oscTick) begin
					bitCnt <= bitCnt + 32'd1; // RQ15
				end
				if (timer == 32'd0)
					bitCnt <= 32'd0;
				if (bitCnt >= `PSL_INIT_CYCLES) begin // RQ17
					userIoEnable <= 1'b1; // RQ19
					weakPullupOn <= 1'b0;
					stage        <= `PSL_ST_USER;
				end
				if (timer == 32'd0)
					timer <= 32'd1;
			end
			`PSL_ST_USER: begin
				if (!reqHigh) begin // RQ23
					holdStatus   <= 1'b1;
					holdDone     <= 1'b1;
					userIoEnable <= 1'b0;
					stage        <= `PSL_ST_RESET;
				end
			end
			`PSL_ST_ERR: begin
				timer <= timer + 32'd1;
				if (!reqHigh) begin
					stage <= `PSL_ST_RESET;
				end else if (autoRestart && timer >= ERR_CYCLES - 32'd1) begin // RQ21
					holdStatus <= 1'b0;
					stage      <= `PSL_ST_RESET;
				end
			end
			default: stage <= `PSL_ST_POR;
			endcase
			if (reqRise && stage == `PSL_ST_POR)
				reqPrev <= reqHigh;
		end
	end

	// ==================================================================
	// Bitstream buffer
	// ==================================================================
	psl_fifo #(
		.WIDTH (`PSL_WORD_W),
		.DEPTH (`PSL_FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.flush    (stage == `PSL_ST_RESET),
		.inData   (shiftReg),
		.inValid  (wordValid),
		.inReady  (wordReady),
		.outData  (frameData),
		.outValid (frameValid),
		.outReady (frameReady)
	);

	// ==================================================================
	// Open-drain pins
	// ==================================================================
	// Open-drain: the pins only ever pull low.
	assign statusOut   = 1'b0;
	assign statusOe    = holdStatus; // RQ2 RQ9 RQ21
	assign loadDoneOut = 1'b0;
	assign loadDoneOe  = holdDone; // RQ23
	assign initDoneOut = 1'b0;
	assign initDoneOe  = optInitDone & (stage != `PSL_ST_USER) &
	                     (stage != `PSL_ST_RESET) & (stage != `PSL_ST_POR); // RQ18 RQ19

endmodule // psl_config_load

`default_nettype wire

/* core/psl_regs.vh */
// Constants for the passive serial configuration loader.
// Assumes a 100 MHz system clock; included by the loader core, its checker and its bench, but not by the FIFO.
//
// Behaviour
// [RQ1] Power-on delay is 100 ms with delay select low, 12 ms when high.
// [RQ2] During power-on reset hold status low and user I/O in high impedance.
// [RQ3] The memory runs its own power-on delay of 200, 100 or 2 ms.
// [RQ4] The memory holds its output-enable low during its power-on delay.
// [RQ5] Pick delays so the target powers up first; 12 ms with 100 ms.
// [RQ6] Each party releases its open-drain line after power-on; I/O stays floating.
// [RQ7] Weak pull-up select low enables weak pull-ups after power-on until user mode.
// [RQ8] A rising request line starts a cycle: reset, configuration, initialization.
// [RQ9] Stay in reset while the request line or status line is low.
// [RQ10] Request high leaves reset, releases status, and accepts configuration data.
// [RQ11] With status high the memory shifts the bitstream with the serial clock.
// [RQ12] Capture each data bit on the rising edge of the serial load clock.
// [RQ13] After all data without error release load-complete; its rise starts initialization.
// [RQ14] The memory stops sending when load-complete, its chip select, goes high.
// [RQ15] Initialization runs from the internal 10 MHz oscillator or the user startup clock.
// [RQ16] The user startup clock has no effect on the configuration stage.
// [RQ17] With user clock selected, 299 of its cycles after a fixed delay reach user mode.
// [RQ18] Initialization-done floats high, then goes low once its enable bit arrives.
// [RQ19] When initialization completes, release initialization-done to signal user mode.
// [RQ20] The memory restart output may drive the request line; optional.
// [RQ21] On error drive status low, reset, and release after at most 100 us; the code releases on the timeout only with autoRestart high.
// [RQ22] The memory waits 64 or 16 serial clocks for load-complete, then flags failure.
// [RQ23] In user mode a 2 us low request restarts: status and load-complete low, I/O float.
// [RQ24] The initialization counter counts selected clock edges after load-complete is seen high.
// [RQ25] Synchronise the request and status inputs before they change the stage.
`ifndef PSL_REGS_VH
`define PSL_REGS_VH

// ==========================================================================
// Timing
// ==========================================================================
`define PSL_CLK_MHZ            100
`define PSL_POR_LONG_MS        100
`define PSL_POR_SHORT_MS       12
`define PSL_ERR_TIMEOUT_US     100
`define PSL_OSC_MHZ            10
`define PSL_INIT_CYCLES        299
`define PSL_OSC_INIT_CYCLES    299
`define PSL_CD2CU_DCLKS        4
`define PSL_SERIAL_LOAD_CLOCK_MAX_PERIOD_NS 160

// ==========================================================================
// Stage encoding
// ==========================================================================
`define PSL_ST_POR   3'h0
`define PSL_ST_RESET 3'h1
`define PSL_ST_CONF  3'h2
`define PSL_ST_WAIT  3'h3
`define PSL_ST_INIT  3'h4
`define PSL_ST_USER  3'h5
`define PSL_ST_ERR   3'h6

// ==========================================================================
// Bitstream framing
// ==========================================================================
`define PSL_WORD_W       8
`define PSL_FIFO_DEPTH   16
`define PSL_OPT_INITDONE 0

`endif

/* core/psl_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module psl_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset.
	input  wire             clk,
	input  wire             rst_n,
	input  wire             flush,
	// Write side.
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	// Read side.
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr;
	reg [AW-1:0]    rdPtr;
	reg [AW:0]      count;

	localparam [AW:0] FULL_COUNT = DEPTH;

	wire push = inValid & inReady;
	wire pop  = outValid & outReady;

	assign inReady  = (count != FULL_COUNT);
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr];

	always @(posedge clk) begin
		if (push)
			mem[wrPtr] <= inData;
	end

	always @(posedge clk) begin
		if (!rst_n || flush) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

endmodule // psl_fifo

`default_nettype wire

/* sim/psl_config_load_sva.sv */
// Checker for the configuration loader stage outputs.
// Assumes binding to psl_config_load; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "psl_regs.vh"
module psl_config_load_sva (
	// Clock and reset.
	input wire logic       clk,
	input wire logic       rst_n,
	// Pin levels.
	input wire logic       configRequestN,
	input wire logic       statusIn,
	input wire logic       loadDoneIn,
	input wire logic       weakPullupSelectN,
	input wire logic       dataError,
	// Outputs watched.
	input wire logic       statusOe,
	input wire logic       loadDoneOe,
	input wire logic       initDoneOe,
	input wire logic       userIoEnable,
	input wire logic       weakPullupOn,
	input wire logic [2:0] stage
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_userAbort;
		stage == `PSL_ST_USER ##1 !configRequestN [*8];
	endsequence
	sequence s_doneSeen;
		stage == `PSL_ST_WAIT && loadDoneIn ##1 loadDoneIn;
	endsequence
	chk_por_hold: assert property (stage == `PSL_ST_POR |-> statusOe && !userIoEnable)
		else $error("status or I/O released in power-on");
	chk_reset_wait: assert property ((!configRequestN || !statusIn) [*4] ##0
		stage == `PSL_ST_RESET |=> stage == `PSL_ST_RESET) else $error("left reset early");
	chk_conf_lines: assert property (stage == `PSL_ST_CONF |-> !statusOe && loadDoneOe)
		else $error("lines wrong while loading");
	chk_done_free: assert property (stage == `PSL_ST_WAIT [*2] |-> !loadDoneOe)
		else $error("load-complete still held");
	chk_init_entry: assert property (s_doneSeen |-> ##[0:4] stage == `PSL_ST_INIT)
		else $error("initialization not entered");
	chk_user_out: assert property (stage == `PSL_ST_USER |->
		userIoEnable && !initDoneOe && !weakPullupOn) else $error("user mode outputs wrong");
	chk_pullup_conf: assert property ((stage == `PSL_ST_CONF &&
		$stable(weakPullupSelectN)) [*4] |-> weakPullupOn == !weakPullupSelectN)
		else $error("weak pull-up level wrong");
	chk_user_abort: assert property (s_userAbort |-> ##[0:300]
		(statusOe && loadDoneOe && !userIoEnable)) else $error("no restart from user mode");
	chk_error_flag: assert property (dataError && stage == `PSL_ST_CONF |=> ##[0:3] statusOe)
		else $error("error not flagged on status");
endmodule // psl_config_load_sva
`default_nettype wire

/* sim/psl_cfg_mem.sv */
// Behavioural serial configuration memory feeding the loader.
// Assumes resolved open-drain line levels from the bench.
`timescale 1ns/1ps
`default_nettype none
module psl_cfg_mem #(parameter int NB = 16) (
	// Shared lines.
	input  wire logic          statusLine,
	input  wire logic          selectN,
	input  wire logic [NB-1:0] image,
	// Memory outputs.
	output logic               oeLow,
	output logic               serial_load_clock,
	output logic               dout
);
	initial begin
		oeLow = 1'b1;
		serial_load_clock = 1'b0;
		dout = 1'b0;
		#1500 oeLow = 1'b0;
		forever begin
			wait (statusLine === 1'b1 && selectN === 1'b0);
			#500;
			for (int i = NB - 1; i >= 0 && statusLine === 1'b1 && selectN === 1'b0; i--) begin
				dout = image[i];
				#80 serial_load_clock = 1'b1;
				#80 serial_load_clock = 1'b0;
			end
			for (int k = 0; k < 64 && selectN === 1'b0; k++) #160;
			if (selectN === 1'b0 && statusLine === 1'b1) begin
				oeLow = 1'b1;
				#200 oeLow = 1'b0;
			end
			dout = ~dout;
			wait (statusLine !== 1'b1 || selectN === 1'b1);
			wait (selectN === 1'b0);
		end
	end
endmodule // psl_cfg_mem
`default_nettype wire

/* sim/psl_config_load_tb.sv */
// Self-checking bench for the passive serial configuration loader.
// Assumes design, checker and memory model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "psl_regs.vh"
module psl_config_load_tb;
	logic clk = 0, rst_n = 0, configRequestN = 1, delaySel = 0, pullN = 0, holdSt = 1;
	logic userClk = 0, ucRun = 0, useUser = 0, autoRestart = 0, dataError = 0, frameReady = 0;
	logic statusOe, loadDoneOe, initDoneOe, oeLow, serial_load_clock, dout, frameValid, loadOverrun;
	logic userIoEnable, weakPullupOn;
	logic [7:0] frameData, rnd = 8'h54;
	logic [15:0] image = 16'h0;
	logic [2:0] stage;
	int err_total = 0, compares = 0, cyc = 0, n, t0;
	wire statusLine = !(statusOe | oeLow | holdSt);
	wire doneLine = !loadDoneOe;
	always #5 clk = ~clk;
	always #15 if (ucRun) userClk = ~userClk;
	psl_config_load #(.POR_LONG_CYCLES(32'd200), .POR_SHORT_CYCLES(32'd50), .FRAME_BITS(32'd16)) uut (
		.clk(clk), .rst_n(rst_n), .configRequestN(configRequestN),
		.powerOnDelaySelect(delaySel), .weakPullupSelectN(pullN), .statusIn(statusLine),
		.statusOut(), .statusOe(statusOe), .loadDoneIn(doneLine), .loadDoneOut(),
		.loadDoneOe(loadDoneOe), .serialLoadClock(serial_load_clock), .serialLoadInput(dout),
		.userStartupClock(userClk), .initDoneOut(), .initDoneOe(initDoneOe),
		.useUserStartupClock(useUser), .autoRestart(autoRestart), .dataError(dataError),
		.userIoEnable(userIoEnable), .weakPullupOn(weakPullupOn), .frameData(frameData),
		.frameValid(frameValid), .frameReady(frameReady), .loadOverrun(loadOverrun),
		.stage(stage));
	psl_cfg_mem #(.NB(16)) mem (.statusLine(statusLine), .selectN(doneLine), .image(image),
		.oeLow(oeLow), .serial_load_clock(serial_load_clock), .dout(dout));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic ck(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic waitSt(input logic [2:0] s, input int lim);
		n = 0;
		while (stage !== s && n < lim) begin
			@(posedge clk);
			#1 n++;
		end
		ck(stage === s, "stage not reached");
	endtask
	task automatic statusWait(input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (statusOe !== 1'b0 && n < lim);
	endtask
	// ==========================================================
	// One full load; with usr low the user clock runs unselected to show it is ignored, with usr high it stays stopped until init is shown stalled.
	// ==========================================================
	task automatic load(input logic opt, input logic usr);
		image = {opt, rnd[6:0], lfsr(rnd)};
		rnd = lfsr(lfsr(rnd));
		repeat (4) @(posedge clk);
		useUser <= usr;
		ucRun = !usr;
		holdSt <= 1'b0;
		waitSt(`PSL_ST_INIT, 4000);
		ck(initDoneOe === opt, "init done level");
		ck(loadOverrun === 1'b0 && frameValid === 1'b1, "frame not buffered");
		for (int b = 1; b >= 0; b--) begin
			ck(frameData === image[b*8 +: 8] && frameValid === 1'b1, "frame byte");
			frameReady <= 1'b1;
			@(posedge clk);
			#1 frameReady <= 1'b0;
			@(posedge clk);
			#1;
		end
		if (usr) begin
			repeat (400) @(posedge clk);
			ck(stage === `PSL_ST_INIT, "ran without user clock");
			ucRun = 1'b1;
		end
		t0 = cyc;
		waitSt(`PSL_ST_USER, 5000);
		ck(cyc - t0 >= (usr ? 880 : 2960) && cyc - t0 <= (usr ? 915 : 3010), "init length");
		ucRun = 1'b0;
		ck(userIoEnable === 1 && initDoneOe === 0 && weakPullupOn === 0, "user mode");
	endtask
	task automatic abortUser;
		configRequestN <= 1'b0;
		repeat (250) @(posedge clk);
		ck(statusOe === 1 && loadDoneOe === 1 && userIoEnable === 0, "restart");
		holdSt <= 1'b1;
		configRequestN <= 1'b1;
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		for (int s = 0; s < 2; s++) begin
			rst_n <= 1'b0;
			delaySel <= s[0];
			repeat (2) @(posedge clk);
			rst_n <= 1'b1;
			statusWait(400);
			ck(n >= (s ? 50 : 200) && n <= (s ? 55 : 205), "power-on length");
			repeat (20) @(posedge clk);
			ck(stage === `PSL_ST_RESET, "left reset, status low");
		end
		configRequestN <= 1'b0;
		holdSt <= 1'b0;
		repeat (30) @(posedge clk);
		ck(stage === `PSL_ST_RESET, "left reset, request low");
		holdSt <= 1'b1;
		configRequestN <= 1'b1;
		pullN <= rnd[0];
		load(1'b1, 1'b0);
		abortUser();
		load(1'b0, 1'b1);
		abortUser();
		autoRestart <= 1'b1;
		holdSt <= 1'b0;
		waitSt(`PSL_ST_CONF, 2000);
		repeat (100) @(posedge clk);
		dataError <= 1'b1;
		@(posedge clk);
		dataError <= 1'b0;
		repeat (4) @(posedge clk);
		ck(statusOe === 1'b1, "error not flagged");
		statusWait(12000);
		ck(n <= 10010, "error timeout");
		load(rnd[2], 1'b0);
		give_verdict();
	end
endmodule // psl_config_load_tb
bind psl_config_load psl_config_load_sva chk (.clk(clk), .rst_n(rst_n),
	.configRequestN(configRequestN), .statusIn(statusIn), .loadDoneIn(loadDoneIn),
	.weakPullupSelectN(weakPullupSelectN), .dataError(dataError), .statusOe(statusOe),
	.loadDoneOe(loadDoneOe), .initDoneOe(initDoneOe), .userIoEnable(userIoEnable),
	.weakPullupOn(weakPullupOn), .stage(stage));
`default_nettype wire
